// File: rtl/pcs_pkg.sv
// Purpose: shared constants for the program counter and return stack
// Assumes: one instruction cycle per core clock enable-free cycle
// Notes: widths and encodings of the counter operations
package pcs_pkg;
  // ==========================================================
  // widths
  localparam int PCS_PC_W = 12;
  localparam int PCS_ROM_AW = 11;
  localparam int PCS_PAGE_W = 10;
  localparam int PCS_LOW_W = 8;
  localparam int PCS_STACK_DEPTH = 8;
  localparam int PCS_SP_W = 3;
  localparam int PCS_PAGE_WORDS = 1024;
  localparam int PCS_ROM_WORDS = 2048;
  localparam int PCS_ROM_DW = 13;
  // ==========================================================
  // field positions
  localparam int PCS_PAGE_MSB_POS = 10;
  localparam int PCS_STATUS_PAGE_POS = 5;
  // ==========================================================
  // reset values and the counter increment
  localparam logic [11:0] PCS_PC_RESET = 12'h000;
  localparam logic [2:0] PCS_SP_RESET = 3'h0;
  localparam logic [11:0] PCS_PC_ONE = 12'h001;
  // ==========================================================
  // operations from the instruction decoder
  typedef enum logic [2:0] {
    PCS_OP_NEXT = 3'h0,
    PCS_OP_JUMP = 3'h1,
    PCS_OP_CALL = 3'h2,
    PCS_OP_RET = 3'h3,
    PCS_OP_ADD = 3'h4,
    PCS_OP_WRITE = 3'h5
  } pcs_op_t;
  // ==========================================================
  // sequencing states, one-hot
  typedef enum logic [1:0] {
    PCS_ST_RUN = 2'h1,
    PCS_ST_WAIT = 2'h2
  } pcs_state_t;
endpackage

// File: rtl/pcs_stack.sv
// Purpose: circular return stack of counter values
// Assumes: push and pop never asserted together
// Notes: wraps silently on overflow and underflow
`timescale 1ns/1ps
module pcs_stack
  import pcs_pkg::*;
#(
  parameter int DEPTH = PCS_STACK_DEPTH,
  parameter int WIDTH = PCS_PC_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // push and pop
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_push_data,
  input wire logic i_pop,
  // top entry
  output logic [WIDTH-1:0] o_top
);
  logic [WIDTH-1:0] entry [DEPTH];
  logic [PCS_SP_W-1:0] sp;
  logic [PCS_SP_W-1:0] sp_top;

  // sp points at next free slot; top is the slot below it
  assign sp_top = sp - 3'h1;
  assign o_top = entry[sp_top];

  // ==========================================================
  // pointer, wrapping without error flag
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp <= PCS_SP_RESET;
    end else if (i_push) begin
      sp <= sp + 3'h1;
    end else if (i_pop) begin
      sp <= sp_top;
    end
  end

  // ==========================================================
  // entries, oldest overwritten after eight pushes
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < DEPTH; k++) begin
        entry[k] <= PCS_PC_RESET;
      end
    end else if (i_push) begin
      entry[sp] <= i_push_data;
    end
  end

  a_wrap_after_eight: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (i_push && !i_pop) [*8] |=> (sp == $past(sp, 8)))
    else $error("stack pointer did not wrap after eight pushes");
endmodule // pcs_stack

// File: rtl/pcs_core.sv
// Purpose: program counter with page select and return stack
// Assumes: decoder holds op stable until o_op_done
// Notes: counter write may take an extra cycle per option bit
`timescale 1ns/1ps
module pcs_core
  import pcs_pkg::*;
#(
  parameter int PC_W = PCS_PC_W,
  parameter int DEPTH = PCS_STACK_DEPTH
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // decoder request
  input wire logic i_op_valid,
  input wire pcs_op_t i_op,
  input wire logic [PCS_PAGE_W-1:0] i_target,
  input wire logic [PCS_LOW_W-1:0] i_accum,
  input wire logic [PCS_LOW_W-1:0] i_reg_write_data,
  input wire logic [PCS_LOW_W-1:0] i_status_register_word,
  input wire logic i_jump_cycle_option,
  // answer
  output logic o_op_done,
  // rom address and counter view
  output logic [PCS_ROM_AW-1:0] o_rom_addr,
  output logic [PC_W-1:0] o_program_counter_register
);
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] stack_top;
  logic page_select_bit;
  logic push;
  logic pop;
  logic is_write;
  logic step;
  pcs_state_t state;
  pcs_state_t next_state;

  // ==========================================================
  // decode
  assign page_select_bit = i_status_register_word[PCS_STATUS_PAGE_POS];
  assign pc_inc = pc + PCS_PC_ONE;
  assign is_write = (i_op == PCS_OP_ADD) || (i_op == PCS_OP_WRITE);

  // counter writes with the option set wait one extra cycle
  always_comb begin
    next_state = state;
    step = 1'b0;
    case (state)
      PCS_ST_RUN: begin
        if (i_op_valid && is_write && i_jump_cycle_option) begin
          next_state = PCS_ST_WAIT;
        end else begin
          step = 1'b1;
        end
      end
      PCS_ST_WAIT: begin
        next_state = PCS_ST_RUN;
        step = 1'b1;
      end
      default: begin
        next_state = PCS_ST_RUN;
      end
    endcase
  end

  assign o_op_done = step;
  assign push = step && i_op_valid && (i_op == PCS_OP_CALL);
  assign pop = step && i_op_valid && (i_op == PCS_OP_RET);

  // ==========================================================
  // next counter value
  always_comb begin
    next_pc = pc_inc;
    if (i_op_valid) begin
      case (i_op)
        PCS_OP_JUMP, PCS_OP_CALL: begin
          next_pc = {pc[PC_W-1], page_select_bit, i_target};
        end
        PCS_OP_RET: begin
          // stack value used whole; page select not consulted
          next_pc = stack_top;
        end
        PCS_OP_ADD: begin
          next_pc = pc + {4'h0, i_accum};
          next_pc[PCS_PAGE_MSB_POS] = page_select_bit;
        end
        PCS_OP_WRITE: begin
          next_pc = {pc[PC_W-1], page_select_bit, pc[9:8],
                     i_reg_write_data};
        end
        default: begin
          next_pc = pc_inc;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= PCS_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // counter register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc <= PCS_PC_RESET;
    end else if (step) begin
      pc <= next_pc;
    end
  end

  assign o_program_counter_register = pc;
  // page-select driven bit ten plus ten page bits reach the rom
  assign o_rom_addr = pc[PCS_ROM_AW-1:0];

  // ==========================================================
  // return stack
  pcs_stack #(
    .DEPTH(DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_push(push),
    .i_push_data(pc_inc),
    .i_pop(pop),
    .o_top(stack_top)
  );

  // ==========================================================
  // checks
  // cycles without a counter update; a write may stall only once
  logic [1:0] stall_cnt;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stall_cnt <= 2'h0;
    end else if (o_op_done) begin
      stall_cnt <= 2'h0;
    end else if (stall_cnt != 2'h3) begin
      stall_cnt <= stall_cnt + 2'h1;
    end
  end

  // one decoded op per cycle, so a call and a return are never one step
  sequence s_call_taken;
    push;
  endsequence

  sequence s_ret_taken;
    pop;
  endsequence

  // first cycle of a counter write that the option stretches
  sequence s_write_held;
    (state == PCS_ST_RUN) && i_op_valid && is_write && i_jump_cycle_option;
  endsequence

  sequence s_wait_done;
    (state == PCS_ST_WAIT) && o_op_done;
  endsequence

  sequence s_jump_step;
    step && i_op_valid && (i_op == PCS_OP_JUMP);
  endsequence

  sequence s_add_step;
    step && i_op_valid && (i_op == PCS_OP_ADD);
  endsequence

  sequence s_write_step;
    step && i_op_valid && (i_op == PCS_OP_WRITE);
  endsequence

  a_jump_target: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_jump_step |=> (pc[9:0] == $past(i_target)))
    else $error("jump target not loaded");

  a_call_target: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_call_taken |=> (pc[9:0] == $past(i_target) &&
      stack_top == $past(pc_inc)))
    else $error("call target or pushed address wrong");

  a_call_return: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_call_taken ##1 s_ret_taken |=> (pc == $past(pc_inc, 2)))
    else $error("immediate return did not resume after call");

  // two deep: the outer return must still find the older entry
  a_nested_return: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_call_taken ##1 s_call_taken ##1 s_ret_taken ##1 s_ret_taken |=>
      (pc == $past(pc_inc, 4)))
    else $error("outer return did not resume after outer call");

  a_ret_top: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_ret_taken |=> (pc == $past(stack_top)))
    else $error("return did not load the stack top");

  // page select disagreeing with the saved page must not win
  a_ret_page_kept: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (s_ret_taken ##0 (stack_top[PCS_PAGE_MSB_POS] != page_select_bit)) |=>
      (pc[PCS_PAGE_MSB_POS] != $past(page_select_bit)))
    else $error("return took its page from page select");

  a_page_msb: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (step && i_op_valid && i_op inside {PCS_OP_JUMP, PCS_OP_CALL,
      PCS_OP_ADD, PCS_OP_WRITE}) |=>
      (pc[PCS_PAGE_MSB_POS] == $past(page_select_bit)))
    else $error("page msb not taken from page select");

  // bit eleven never reaches the rom; only adds, returns and plain advances move it
  a_high_bit_kept: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (step && i_op_valid && i_op inside {PCS_OP_JUMP, PCS_OP_CALL,
      PCS_OP_WRITE}) |=> (pc[PC_W-1] == $past(pc[PC_W-1])))
    else $error("jump or write changed counter bit eleven");

  a_write_keeps_89: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_write_step |=> (pc[9:8] == $past(pc[9:8]) &&
      pc[7:0] == $past(i_reg_write_data)))
    else $error("counter write changed bits eight or nine");

  a_add_carry: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_add_step |=>
      (pc[9:0] == 10'($past(pc) + {4'h0, $past(i_accum)})))
    else $error("relative add did not carry");

  // carry out of the page still reaches bit eleven
  a_add_high_carry: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_add_step |=> ((pc & 12'hBFF) ==
      (12'($past(pc) + {4'h0, $past(i_accum)}) & 12'hBFF)))
    else $error("relative add lost its carry into bit eleven");

  a_plain_advance: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (step && !i_op_valid) |=> (pc == 12'($past(pc) + 12'h001)))
    else $error("counter did not advance by one");

  a_next_op_advance: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (step && i_op_valid && i_op == PCS_OP_NEXT) |=>
      (pc == 12'($past(pc) + 12'h001)))
    else $error("plain op code did not advance the counter");

  a_write_two_cyc: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    s_write_held |-> !o_op_done ##1 s_wait_done)
    else $error("counter write did not take two cycles");

  // the counter must not move while a stretched write waits
  a_wait_holds_pc: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (state == PCS_ST_WAIT) |-> $stable(pc))
    else $error("counter moved during the wait cycle");

  a_one_cycle_op: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (state == PCS_ST_RUN && !(i_op_valid && is_write)) |-> o_op_done)
    else $error("plain instruction took more than one cycle");

  a_stall_bound: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b)
    (stall_cnt <= 2'h1))
    else $error("instruction held for more than two cycles");

  a_reset_zero: assert property (@(posedge i_core_clk)
    $rose(i_rst_b) |-> (pc == PCS_PC_RESET && state == PCS_ST_RUN))
    else $error("counter not zero after reset");
endmodule // pcs_core

// File: dv/pcs_rom_model.sv
// Purpose: program memory seen by the counter, one word per address
// Assumes: word answers the address in the same cycle
// Notes: word pattern lets the bench tell every address apart
`timescale 1ns/1ps
module pcs_rom_model
  import pcs_pkg::*;
(
  // fetch address
  input wire logic [PCS_ROM_AW-1:0] i_addr,
  // fetched word
  output logic [PCS_ROM_DW-1:0] o_word
);
  // ==========================================================
  // 2K words of 13 bits, no hole anywhere
  assign o_word = {i_addr[1:0], i_addr};
endmodule // pcs_rom_model

// File: dv/testbench.sv
// Purpose: self-checking bench for the program counter and stack
// Assumes: decoder requests driven 1 ns after the rising edge
// Notes: a shadow counter and stack give every check_pc expectation; cycle counts and page bits come from each scenario
`timescale 1ns/1ps
module testbench
  import pcs_pkg::*;
();
  logic i_core_clk, i_rst_b, i_op_valid, i_jump_cycle_option, o_op_done;
  pcs_op_t i_op;
  logic [PCS_PAGE_W-1:0] i_target;
  logic [PCS_LOW_W-1:0] i_accum, i_reg_write_data, i_status_register_word;
  logic [PCS_ROM_AW-1:0] o_rom_addr;
  logic [PCS_PC_W-1:0] o_program_counter_register, exp_pc;
  logic [PCS_ROM_DW-1:0] rom_word;
  logic [PCS_PC_W-1:0] stk [PCS_STACK_DEPTH];
  logic [PCS_SP_W-1:0] sp;
  int fails, samples_checked;

  pcs_core DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_target(i_target),
    .i_accum(i_accum), .i_reg_write_data(i_reg_write_data),
    .i_status_register_word(i_status_register_word),
    .i_jump_cycle_option(i_jump_cycle_option), .o_op_done(o_op_done),
    .o_rom_addr(o_rom_addr),
    .o_program_counter_register(o_program_counter_register));
  pcs_rom_model u_rom (.i_addr(o_rom_addr), .o_word(rom_word));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ==========================================================
  // checking
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic check_pc();
    check(16'(o_program_counter_register), 16'(exp_pc));
    check(16'(o_rom_addr), 16'(exp_pc[10:0]));
    check(16'(rom_word), 16'({exp_pc[1:0], exp_pc[10:0]}));
  endtask

  task automatic end_sim();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // decoder driving; called 1 ns after an edge
  task automatic do_op(input pcs_op_t op, input logic [9:0] tgt,
      input logic [7:0] val, input logic ps, input int cyc);
    int n;
    i_op_valid = 1'b1;
    i_op = op;
    i_target = tgt;
    i_accum = val;
    i_reg_write_data = val;
    i_status_register_word = {2'h0, ps, 5'h00};
    // done is combinational, so look at it mid-cycle
    for (n = 1; n <= 4; n++) begin
      @(negedge i_core_clk);
      if (o_op_done === 1'b1) break;
      @(posedge i_core_clk);
    end
    if (n > 4) begin
      fails++;
      end_sim();
    end
    @(posedge i_core_clk);
    #1;
    check(16'(n), 16'(cyc));
    case (op)
      PCS_OP_JUMP: exp_pc = {exp_pc[11], ps, tgt};
      PCS_OP_CALL: begin
        stk[sp] = exp_pc + 12'h001;
        sp = sp + 3'h1;
        exp_pc = {exp_pc[11], ps, tgt};
      end
      PCS_OP_RET: begin
        sp = sp - 3'h1;
        exp_pc = stk[sp];
      end
      PCS_OP_ADD: begin
        exp_pc = exp_pc + {4'h0, val};
        exp_pc[10] = ps;
      end
      PCS_OP_WRITE: begin
        exp_pc = {exp_pc[11], ps, exp_pc[9:8], val};
      end
      default: exp_pc = exp_pc + 12'h001;
    endcase
    check_pc();
  endtask

  task automatic step();
    i_op_valid = 1'b0;
    i_op = PCS_OP_NEXT;
    @(posedge i_core_clk);
    #1;
    exp_pc = exp_pc + 12'h001;
    check_pc();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_jump();
    do_op(PCS_OP_JUMP, 10'h3FF, 8'h00, 1'b1, 1);
    check(16'(o_rom_addr[10]), 16'h0001);
    do_op(PCS_OP_JUMP, 10'h000, 8'h00, 1'b0, 1);
    check(16'(o_rom_addr[10]), 16'h0000);
    step();
    do_op(PCS_OP_NEXT, 10'h155, 8'hAA, 1'b1, 1);
  endtask

  task automatic t_call();
    int i;
    do_op(PCS_OP_JUMP, 10'h2A0, 8'h00, 1'b1, 1);
    do_op(PCS_OP_CALL, 10'h010, 8'h00, 1'b1, 1);
    step();
    // page select low at return must not move us off the calling page
    do_op(PCS_OP_RET, 10'h000, 8'h00, 1'b0, 1);
    check(16'(o_rom_addr[10]), 16'h0001);
    // nine deep: one past the stack, oldest entry lost
    for (i = 0; i < 9; i++) begin
      do_op(PCS_OP_CALL, 10'(i * 37), 8'h00, i[0], 1);
    end
    for (i = 0; i < 10; i++) begin
      do_op(PCS_OP_RET, 10'h000, 8'h00, 1'b0, 1);
    end
  endtask

  task automatic t_add_write();
    do_op(PCS_OP_JUMP, 10'h355, 8'h00, 1'b0, 1);
    do_op(PCS_OP_WRITE, 10'h000, 8'hFF, 1'b0, 1);
    do_op(PCS_OP_ADD, 10'h000, 8'h01, 1'b0, 1);
    do_op(PCS_OP_JUMP, 10'h3FF, 8'h00, 1'b1, 1);
    do_op(PCS_OP_ADD, 10'h000, 8'h02, 1'b1, 1);
    i_jump_cycle_option = 1'b1;
    do_op(PCS_OP_WRITE, 10'h000, 8'h5A, 1'b1, 2);
    do_op(PCS_OP_ADD, 10'h000, 8'h10, 1'b0, 2);
    do_op(PCS_OP_JUMP, 10'h1C3, 8'h00, 1'b0, 1);
    step();
  endtask

  // reset in mid-run with a call on the stack
  task automatic t_reset();
    do_op(PCS_OP_CALL, 10'h0AA, 8'h00, 1'b1, 1);
    i_rst_b = 1'b0;
    exp_pc = '0;
    sp = '0;
    foreach (stk[k]) stk[k] = '0;
    @(posedge i_core_clk);
    #1;
    check_pc();
    i_rst_b = 1'b1;
    step();
    do_op(PCS_OP_RET, 10'h000, 8'h00, 1'b0, 1);
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_op_valid = 1'b0;
    i_op = PCS_OP_NEXT;
    i_target = '0;
    i_accum = '0;
    i_reg_write_data = '0;
    i_status_register_word = '0;
    i_jump_cycle_option = 1'b0;
    exp_pc = '0;
    sp = '0;
    fails = 0;
    samples_checked = 0;
    foreach (stk[k]) stk[k] = '0;
    repeat (6) @(posedge i_core_clk);
    #1;
    check_pc();
    i_rst_b = 1'b1;
    repeat (3) step();
    t_jump();
    t_call();
    t_add_write();
    t_reset();
    end_sim();
  end
endmodule // testbench
